// file: pkg/ard_pkg.sv
// Package for the device-side task-file block of two read commands.
// Assumes one 125 MHz clock, an AXI4-Lite master on the register side and a
// media back end on the same clock that reports progress and errors.
//
// Functional notes
// - clean queued completion: BSY0 DRDY1 DF0 DRQ0 ERR0
// - completion SERV shows another queued command ready
// - tag field returns tag, 00h without queuing
// - count register returns REL0, IO1, CD1
// - HOB selects current or previous register value
// - abort if unsupported or overlap disabled
// - abort queued read on invalid tag
// - unrecoverable error loads address, aborts queue
// - failing address split by HOB across bytes
// - ICRC set on Ultra DMA CRC error
// - UNC for uncorrectable data, NM without media
// - MC on media change, then clear pending
// - IDNF for missing or out-of-range address
// - MCR sticky until media query or access
// - ABRT for unsupported, UDMA error, range
// - error status: BSY0 DRQ0 DRDY1, DF, ERR
// - device-select bit always shows selected device
// - device may release bus or transfer directly
// - code C4h is multiple read, packet-prohibited
// - multiple read count 00h means 256 sectors
// - 28-bit address from bytes, LBA bit 6
// - service request sets SERV, nothing else changes
package ard_pkg;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_ERROR = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_LOW = 8'h08;
   localparam logic [7:0] OFS_MID = 8'h0C;
   localparam logic [7:0] OFS_HIGH = 8'h10;
   localparam logic [7:0] OFS_DEVICE = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_FEATURE = 8'h1C;
   localparam logic [7:0] OFS_COMMAND = 8'h20;
   localparam logic [7:0] OFS_DEVCTL = 8'h24;
   localparam logic [7:0] OFS_CONFIG = 8'h28;
   localparam logic [7:0] OFS_MAXTAG = 8'h2C;

   // ----------------------------------------------------------------------
   // shadowed register slots, field positions, codes and reset values
   // ----------------------------------------------------------------------
   localparam int SH_FEAT = 0;
   localparam int SH_COUNT = 1;
   localparam int SH_LOW = 2;
   localparam int SH_MID = 3;
   localparam int SH_HIGH = 4;
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_SERV = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ICRC = 7;
   localparam int ER_UNC = 6;
   localparam int ER_MC = 5;
   localparam int ER_IDNF = 4;
   localparam int ER_MCR = 3;
   localparam int ER_ABRT = 2;
   localparam int ER_NM = 1;
   localparam int DV_LBA = 6;
   localparam int DC_HOB = 7;
   localparam int CF_QUEUE = 0;
   localparam int CF_OVERLAP = 1;
   localparam int CF_PACKET = 2;
   localparam int CF_REMOVABLE = 3;
   localparam int CF_RELEASE = 4;
   localparam int CF_RANGE_ABORT = 5;
   localparam logic [7:0] CMD_QUEUED_READ = 8'h26;
   localparam logic [7:0] CMD_READ_MULTIPLE = 8'hC4;
   localparam logic [7:0] RST_STATUS = 8'h40;
   localparam logic [7:0] RST_CONFIG = 8'h03;
   localparam logic [4:0] RST_MAXTAG = 5'h1F;
   localparam logic [16:0] CNT_FULL_EXT = 17'h10000;
   localparam logic [16:0] CNT_FULL_MULT = 17'h00100;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_EXEC = 5'h02,
      ST_RELEASED = 5'h04,
      ST_XFER = 5'h08,
      ST_PIO = 5'h10
   } ard_state_e;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } ard_axil_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ard_axil_rsp_s;

   // back-end report, same clock domain
   typedef struct packed {
      logic data_ready;
      logic xfer_done;
      logic other_ready;
      logic udma;
      logic err_unc;
      logic err_crc;
      logic err_idnf;
      logic err_range;
      logic err_fault;
      logic err_abort;
      logic media_changed;
      logic media_change_req;
      logic no_media;
      logic [47:0] fail_lba;
   } ard_backend_s;

   // command issued to the back end
   typedef struct packed {
      logic start;
      logic queued;
      logic [4:0] tag;
      logic [47:0] lba;
      logic [16:0] count;
      logic bus_released;
      logic queue_abort;
   } ard_cmd_s;

endpackage

// file: verilog/ard_read_cmd_status.sv
// Task-file logic for the queued 48-bit DMA read and the multiple-sector read.
// Assumes the AXI4-Lite master and the back end both run on aclk, so neither
// needs a synchroniser; back-end pulses are single-cycle.
module ard_read_cmd_status
   import ard_pkg::*;
#(
   parameter logic [7:0] MEDIA_QUERY_CODE = 8'hFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire ard_axil_req_s axi_req,
   output ard_axil_rsp_s axi_rsp,
   input wire ard_backend_s backend,
   output ard_cmd_s cmd
);

   // ----------------------------------------------------------------------
   // state of the block
   // ----------------------------------------------------------------------
   typedef struct packed {
      ard_state_e state;
      logic [4:0][7:0] cur;
      logic [4:0][7:0] prev;
      logic [7:0] dev;
      logic [7:0] devctl;
      logic [7:0] cfg;
      logic [4:0] maxtag;
      logic [7:0] error;
      logic [7:0] status;
      logic [4:0] tag;
      logic mc_pend;
      logic mcr_pend;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [7:0] wdata;
      logic wstrb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      ard_cmd_s cmd;
   } ard_regs_s;

   ard_regs_s r;
   ard_regs_s next_r;
   logic wr_go;
   logic cmd_wr;
   logic any_err;
   logic tag_on;
   logic [4:0] tag_field;
   logic [7:0] err_v;
   logic [15:0] ext_count;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // true for every address that holds a register
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         OFS_ERROR, OFS_COUNT, OFS_LOW, OFS_MID, OFS_HIGH, OFS_DEVICE, OFS_STATUS,
         OFS_FEATURE, OFS_COMMAND, OFS_DEVCTL, OFS_CONFIG, OFS_MAXTAG: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // read view of one register; write-only registers read as zero
   function automatic logic [7:0] rd_byte(input ard_regs_s s, input logic [7:0] a);
      logic hob;
      hob = s.devctl[DC_HOB];
      case (a)
         OFS_ERROR: rd_byte = s.error;
         OFS_COUNT: rd_byte = hob ? s.prev[SH_COUNT] : s.cur[SH_COUNT];
         OFS_LOW: rd_byte = hob ? s.prev[SH_LOW] : s.cur[SH_LOW];
         OFS_MID: rd_byte = hob ? s.prev[SH_MID] : s.cur[SH_MID];
         OFS_HIGH: rd_byte = hob ? s.prev[SH_HIGH] : s.cur[SH_HIGH];
         OFS_DEVICE: rd_byte = s.dev;
         OFS_STATUS: rd_byte = s.status;
         OFS_DEVCTL: rd_byte = s.devctl;
         OFS_CONFIG: rd_byte = s.cfg;
         OFS_MAXTAG: rd_byte = {3'h0, s.maxtag};
         default: rd_byte = 8'h00;
      endcase
   endfunction

   // error outputs; the device bit keeps its value, only the nibble moves
   function automatic ard_regs_s finish_err(input ard_regs_s s, input logic [7:0] e,
                                            input logic fault, input logic load,
                                            input logic [47:0] lba, input logic [4:0] tf);
      ard_regs_s o;
      o = s;
      o.error = e;
      o.status = 8'h00;
      o.status[ST_DRDY] = 1'b1;
      o.status[ST_DF] = fault;
      o.status[ST_ERR] = (e != 8'h00);
      // first failing sector into the address bytes
      if (load) begin
         // low bytes current, high bytes previous
         o.cur[SH_LOW] = lba[7:0];
         o.cur[SH_MID] = lba[15:8];
         o.cur[SH_HIGH] = lba[23:16];
         o.prev[SH_LOW] = lba[31:24];
         o.prev[SH_MID] = lba[39:32];
         o.prev[SH_HIGH] = lba[47:40];
         if (!s.cmd.queued) begin
            o.dev[3:0] = lba[27:24];
         end
      end
      // count register as REL0 IO1 CD1, left alone when ending a multiple read (ST_PIO)
      if (s.state != ST_PIO) begin
         o.cur[SH_COUNT] = {tf, 3'h3};
      end
      o.state = ST_IDLE;
      o.cmd.bus_released = 1'b0;
      o.cmd.queue_abort = s.cmd.queued && (s.state != ST_IDLE);
      finish_err = o;
   endfunction

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------

   // tag reads 00h unless queuing and overlap are both on
   assign tag_on = r.cfg[CF_QUEUE] && r.cfg[CF_OVERLAP];
   assign tag_field = tag_on ? r.tag : 5'h00;
   assign ext_count = {r.prev[SH_FEAT], r.cur[SH_FEAT]};

   // one pass: bus channels, command decode, back-end progress, sticky events
   always_comb begin
      next_r = r;
      next_r.cmd.start = 1'b0;
      next_r.cmd.queue_abort = 1'b0;
      cmd_wr = 1'b0;
      any_err = 1'b0;
      err_v = 8'h00;

      // address and data are taken independently, in either order
      if (r.awready && axi_req.awvalid) begin
         next_r.aw_held = 1'b1;
         next_r.awaddr = axi_req.awaddr;
      end
      if (r.wready && axi_req.wvalid) begin
         next_r.w_held = 1'b1;
         next_r.wdata = axi_req.wdata[7:0];
         next_r.wstrb0 = axi_req.wstrb[0];
      end
      if (r.bvalid && axi_req.bready) begin
         next_r.bvalid = 1'b0;
      end
      wr_go = r.aw_held && r.w_held && !r.bvalid;

      // register write; only byte lane 0 carries data
      if (wr_go) begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = is_mapped(r.awaddr) ? RESP_OKAY : RESP_DECERR;
         if (r.wstrb0) begin
            case (r.awaddr)
               OFS_FEATURE: begin
                  next_r.prev[SH_FEAT] = r.cur[SH_FEAT];
                  next_r.cur[SH_FEAT] = r.wdata;
               end
               OFS_COUNT: begin
                  next_r.prev[SH_COUNT] = r.cur[SH_COUNT];
                  next_r.cur[SH_COUNT] = r.wdata;
               end
               OFS_LOW: begin
                  next_r.prev[SH_LOW] = r.cur[SH_LOW];
                  next_r.cur[SH_LOW] = r.wdata;
               end
               OFS_MID: begin
                  next_r.prev[SH_MID] = r.cur[SH_MID];
                  next_r.cur[SH_MID] = r.wdata;
               end
               OFS_HIGH: begin
                  next_r.prev[SH_HIGH] = r.cur[SH_HIGH];
                  next_r.cur[SH_HIGH] = r.wdata;
               end
               // only the host moves the select bit
               OFS_DEVICE: next_r.dev = r.wdata;
               OFS_DEVCTL: next_r.devctl = r.wdata;
               OFS_CONFIG: next_r.cfg = r.wdata;
               OFS_MAXTAG: next_r.maxtag = r.wdata[4:0];
               OFS_COMMAND: cmd_wr = 1'b1;
               default: ;
            endcase
         end
      end

      // register read, answered the cycle after the address is taken
      if (r.rvalid && axi_req.rready) begin
         next_r.rvalid = 1'b0;
      end
      if (r.arready && axi_req.arvalid) begin
         next_r.rvalid = 1'b1;
         next_r.rdata = {24'h000000, rd_byte(r, axi_req.araddr)};
         next_r.rresp = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_DECERR;
      end

      // a command written while busy or transferring is dropped; DRDY stays set, so the host must wait for ST_IDLE
      if (cmd_wr && (r.state == ST_IDLE) && !r.status[ST_BSY]) begin
         if ((r.wdata == CMD_QUEUED_READ) || (r.wdata == CMD_READ_MULTIPLE) ||
             (r.wdata == MEDIA_QUERY_CODE)) begin
            // media access or query clears the change request
            next_r.mcr_pend = 1'b0;
         end
         next_r.cmd.queued = (r.wdata == CMD_QUEUED_READ);
         err_v[ER_MCR] = r.mcr_pend && r.cfg[CF_REMOVABLE];
         err_v[ER_MC] = r.mc_pend && r.cfg[CF_REMOVABLE];
         err_v[ER_NM] = backend.no_media && r.cfg[CF_REMOVABLE];
         case (r.wdata)
            CMD_QUEUED_READ: begin
               next_r.tag = r.cur[SH_COUNT][7:3];
               if (!tag_on) begin
                  next_r = finish_err(next_r, 8'h04, 1'b0, 1'b0, 48'h0, 5'h00);
               end else if (r.cur[SH_COUNT][7:3] > r.maxtag) begin
                  next_r = finish_err(next_r, 8'h04, 1'b0, 1'b0, 48'h0,
                                      r.cur[SH_COUNT][7:3]);
               end else if (err_v[ER_MC] || err_v[ER_NM]) begin
                  // media changed or absent; change reported, pending state dropped
                  next_r.mc_pend = 1'b0;
                  next_r = finish_err(next_r, err_v, 1'b0, 1'b0, 48'h0,
                                      r.cur[SH_COUNT][7:3]);
               end else begin
                  next_r.state = ST_EXEC;
                  next_r.status = 8'h00;
                  next_r.status[ST_BSY] = 1'b1;
                  next_r.status[ST_DRDY] = 1'b1;
                  next_r.error = 8'h00;
                  next_r.cmd.start = 1'b1;
                  next_r.cmd.tag = r.cur[SH_COUNT][7:3];
                  next_r.cmd.lba = {r.prev[SH_HIGH], r.prev[SH_MID], r.prev[SH_LOW],
                                    r.cur[SH_HIGH], r.cur[SH_MID], r.cur[SH_LOW]};
                  next_r.cmd.count = (ext_count == 16'h0000) ? CNT_FULL_EXT :
                                                               {1'b0, ext_count};
               end
            end
            CMD_READ_MULTIPLE: begin
               // refused where the packet feature set is present
               if (r.cfg[CF_PACKET] || !r.dev[DV_LBA]) begin
                  next_r = finish_err(next_r, 8'h04, 1'b0, 1'b0, 48'h0, 5'h00);
               end else if (err_v[ER_MC] || err_v[ER_NM]) begin
                  next_r.mc_pend = 1'b0;
                  next_r = finish_err(next_r, err_v, 1'b0, 1'b0, 48'h0, 5'h00);
               end else begin
                  next_r.state = ST_PIO;
                  next_r.status = 8'h00;
                  next_r.status[ST_BSY] = 1'b1;
                  next_r.status[ST_DRDY] = 1'b1;
                  next_r.error = 8'h00;
                  next_r.cmd.start = 1'b1;
                  next_r.cmd.tag = 5'h00;
                  next_r.cmd.lba = {20'h00000, r.dev[3:0], r.cur[SH_HIGH], r.cur[SH_MID],
                                    r.cur[SH_LOW]};
                  next_r.cmd.count = (r.cur[SH_COUNT] == 8'h00) ? CNT_FULL_MULT :
                                                                {9'h000, r.cur[SH_COUNT]};
               end
            end
            MEDIA_QUERY_CODE: ;
            default: begin
               next_r = finish_err(next_r, 8'h04, 1'b0, 1'b0, 48'h0, 5'h00);
            end
         endcase
      end

      // back-end progress while a command is running
      any_err = backend.err_unc || backend.err_crc || backend.err_idnf ||
                backend.err_range || backend.err_fault || backend.err_abort;
      if (r.state != ST_IDLE) begin
         if (any_err) begin
            err_v = 8'h00;
            // ICRC only means something in Ultra DMA
            err_v[ER_ICRC] = backend.err_crc && backend.udma;
            err_v[ER_UNC] = backend.err_unc;
            // range fault reported as IDNF unless configured to abort
            err_v[ER_IDNF] = backend.err_idnf ||
                             (backend.err_range && !r.cfg[CF_RANGE_ABORT]);
            // back-end aborts, UDMA errors and aborted range requests
            err_v[ER_ABRT] = backend.err_abort || (backend.err_crc && backend.udma) ||
                             (backend.err_range && r.cfg[CF_RANGE_ABORT]);
            err_v[ER_MCR] = r.mcr_pend && r.cfg[CF_REMOVABLE];
            next_r = finish_err(next_r, err_v, backend.err_fault, 1'b1,
                                backend.fail_lba, tag_field);
         end else begin
            case (r.state)
               ST_EXEC: begin
                  if (backend.data_ready) begin
                     next_r.state = ST_XFER;
                     next_r.status[ST_BSY] = 1'b0;
                     next_r.cur[SH_COUNT] = {tag_field, 3'h2};
                  end else if (r.cfg[CF_RELEASE]) begin
                     // release the bus until data is ready
                     next_r.state = ST_RELEASED;
                     next_r.status[ST_BSY] = 1'b0;
                     next_r.status[ST_SERV] = backend.other_ready;
                     next_r.cur[SH_COUNT] = {tag_field, 3'h6};
                     next_r.cmd.bus_released = 1'b1;
                  end
               end
               ST_RELEASED: begin
                  if (backend.data_ready) begin
                     next_r.status[ST_SERV] = 1'b1;
                     next_r.state = ST_XFER;
                     next_r.cmd.bus_released = 1'b0;
                  end
               end
               ST_XFER: begin
                  if (backend.xfer_done) begin
                     next_r.status = 8'h00;
                     next_r.status[ST_DRDY] = 1'b1;
                     next_r.status[ST_SERV] = backend.other_ready;
                     next_r.cur[SH_COUNT] = {tag_field, 3'h3};
                     next_r.error = 8'h00;
                     next_r.state = ST_IDLE;
                  end
               end
               ST_PIO: begin
                  if (backend.xfer_done) begin
                     next_r.status = 8'h00;
                     next_r.status[ST_DRDY] = 1'b1;
                     next_r.state = ST_IDLE;
                  end
               end
               default: next_r.state = ST_IDLE;
            endcase
         end
      end

      // change event latched, a new event beats the clear
      if (backend.media_changed) begin
         next_r.mc_pend = 1'b1;
      end
      if (backend.media_change_req) begin
         next_r.mcr_pend = 1'b1;
      end

      // ready flags follow the held words so no second item is taken early
      next_r.awready = !next_r.aw_held && !next_r.bvalid;
      next_r.wready = !next_r.w_held && !next_r.bvalid;
      next_r.arready = !next_r.rvalid;
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------

   // synchronous reset; ready flags come up low and rise one edge later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.status <= RST_STATUS;
         r.cfg <= RST_CONFIG;
         r.maxtag <= RST_MAXTAG;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all taken from the state register
   // ----------------------------------------------------------------------
   assign axi_rsp.awready = r.awready;
   assign axi_rsp.wready = r.wready;
   assign axi_rsp.bvalid = r.bvalid;
   assign axi_rsp.bresp = r.bresp;
   assign axi_rsp.arready = r.arready;
   assign axi_rsp.rvalid = r.rvalid;
   assign axi_rsp.rdata = r.rdata;
   assign axi_rsp.rresp = r.rresp;
   assign cmd = r.cmd;

endmodule

// file: dv/ard_read_cmd_status_asserts.sv
// checker bound to the read command block
// assumes one aclk domain with synchronous active-low reset
module ard_read_cmd_status_asserts
   import ard_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire ard_axil_req_s axi_req,
   input wire ard_axil_rsp_s axi_rsp,
   input wire ard_backend_s backend,
   input wire ard_cmd_s cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic errs;
   logic ar_ok;
   // any back-end error pulse; a read address taken
   assign errs = backend.err_unc | backend.err_crc | backend.err_idnf | backend.err_range
      | backend.err_fault | backend.err_abort;
   assign ar_ok = axi_req.arvalid & axi_rsp.arready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_start_pulse; cmd.start |=> !cmd.start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held");
   property p_start_ack; cmd.start |-> $rose(axi_rsp.bvalid); endproperty
   a_start_ack: assert property (p_start_ack) else $error("start off response");
   property p_mult_cnt; cmd.start && !cmd.queued |-> cmd.count inside {[1:256]}; endproperty
   a_mult_cnt: assert property (p_mult_cnt) else $error("bad sector count");
   property p_qa_cause; cmd.queue_abort |-> $past(errs) || $past(errs, 2); endproperty
   a_qa_cause: assert property (p_qa_cause) else $error("abort without error");
   property p_qa_pulse; cmd.queue_abort |=> !cmd.queue_abort; endproperty
   a_qa_pulse: assert property (p_qa_pulse) else $error("abort held");
   property p_rd_lat; ar_ok |=> axi_rsp.rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read late");
   property p_unmap; ar_ok && axi_req.araddr > OFS_MAXTAG |=> axi_rsp.rresp == RESP_DECERR;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read okay");
   property p_drdy; ar_ok && axi_req.araddr == OFS_STATUS
      |=> axi_rsp.rdata[ST_DRDY] && !axi_rsp.rdata[ST_DRQ]; endproperty
   a_drdy: assert property (p_drdy) else $error("status ready bits wrong");
endmodule
bind ard_read_cmd_status ard_read_cmd_status_asserts ard_read_cmd_status_asserts_i (
   .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .backend(backend),
   .cmd(cmd));

// file: dv/ard_backend_model.sv
// back-end model answering each command the block starts
// mode picks a clean end, an uncorrectable error or a crc error
module ard_backend_model
   import ard_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire ard_cmd_s cmd,
   input wire logic [1:0] mode,
   output ard_backend_s backend = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   // another command always ready; data ready, then one ending pulse
   always @(posedge aclk) begin
      backend.other_ready <= 1'b1;
      backend.udma <= 1'b1;
      backend.fail_lba <= 48'hAABBCCDDEEFF;
      cnt <= (cmd.start || cnt != 4'h0) && cnt != 4'h6 && aresetn ? cnt + 4'h1 : 4'h0;
      backend.data_ready <= cnt == 4'h3;
      backend.xfer_done <= cnt == 4'h6 && mode == 2'h0;
      backend.err_unc <= cnt == 4'h6 && mode == 2'h1;
      backend.err_crc <= cnt == 4'h6 && mode == 2'h2;
   end
endmodule

// file: dv/ard_read_cmd_status_tb.sv
// bench for the read command block over its register bus
// assumes the back-end model closes every started command
module ard_read_cmd_status_tb
   import ard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [7:0] e; logic [1:0] r;} ard_row_s;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [1:0] mode = 2'h0;
   logic qa_seen = 1'b0;
   logic rel_seen = 1'b0;
   logic [7:0] d;
   logic [1:0] rr;
   int mismatches = 0;
   int comparisons = 0;
   ard_axil_req_s req = '0;
   ard_axil_rsp_s rsp;
   ard_backend_s be;
   ard_cmd_s cmd;
   ard_cmd_s cap = '0;
   ard_row_s rows [6] = '{'{OFS_ERROR, 8'h00, RESP_OKAY}, '{OFS_STATUS, RST_STATUS, RESP_OKAY},
      '{OFS_CONFIG, RST_CONFIG, RESP_OKAY}, '{OFS_MAXTAG, 8'h1F, RESP_OKAY},
      '{OFS_COMMAND, 8'h00, RESP_OKAY}, '{8'h30, 8'h00, RESP_DECERR}};
   // config, maxtag, device, command: each must be refused
   logic [31:0] ab [5] = '{32'h001F4026, 32'h03014026, 32'h031F00C4, 32'h071F40C4, 32'h031F4055};
   always #4 aclk = ~aclk;
   ard_read_cmd_status ard_read_cmd_status_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .backend(be), .cmd(cmd));
   ard_backend_model ard_backend_model_i (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
      .mode(mode), .backend(be));
   // keep the last command issued and note any queue abort
   always @(posedge aclk) begin
      if (cmd.start) cap <= cmd;
      if (cmd.queue_abort) qa_seen <= 1'b1;
      if (cmd.bus_released) rel_seen <= 1'b1;
   end
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, v};
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      fork
         begin do @(posedge aclk); while (rsp.awready !== 1'b1); req.awvalid <= 1'b0; end
         begin do @(posedge aclk); while (rsp.wready !== 1'b1); req.wvalid <= 1'b0; end
      join
      while (rsp.bvalid !== 1'b1) @(posedge aclk);
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge aclk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      while (rsp.rvalid !== 1'b1) @(posedge aclk);
      v = rsp.rdata[7:0];
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, d);
      chk($sformatf("reg %h", a), d, e);
   endtask
   task automatic run(input logic [7:0] c, input logic [1:0] m);
      mode <= m;
      wr(OFS_COMMAND, c);
      d = 8'h80;
      // next command only once busy is clear
      for (int i = 0; i < 40 && d[7] !== 1'b0; i++) rd(OFS_STATUS, d);
      // for a queued read busy already drops in the transfer phase, so let the back end finish
      repeat (6) @(posedge aclk);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // a hang is cut short; the tests need well under 25000 cycles
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i].a, d);
         chk($sformatf("reg %h", rows[i].a), d, rows[i].e);
         chk("resp", rr, rows[i].r);
      end
      $display("reset values done");
      wr(OFS_COUNT, 8'h28);
      run(CMD_QUEUED_READ, 2'h0);
      rc(OFS_STATUS, 8'h50);
      rc(OFS_COUNT, 8'h2B);
      chk("tag", cap.tag, 5'h05);
      wr(OFS_CONFIG, 8'h13);
      run(CMD_QUEUED_READ, 2'h0);
      chk("release", rel_seen, 1'b1);
      wr(OFS_COUNT, 8'h28);
      run(CMD_QUEUED_READ, 2'h1);
      rc(OFS_ERROR, 8'h40);
      rc(OFS_STATUS, 8'h41);
      rc(OFS_LOW, 8'hFF);
      rc(OFS_MID, 8'hEE);
      rc(OFS_HIGH, 8'hDD);
      rc(OFS_COUNT, 8'h2B);
      chk("queue abort", qa_seen, 1'b1);
      wr(OFS_DEVCTL, 8'h80);
      rc(OFS_LOW, 8'hCC);
      rc(OFS_MID, 8'hBB);
      rc(OFS_HIGH, 8'hAA);
      wr(OFS_DEVCTL, 8'h00);
      run(CMD_QUEUED_READ, 2'h2);
      rc(OFS_ERROR, 8'h84);
      $display("queued read done");
      foreach (ab[i]) begin
         wr(OFS_CONFIG, ab[i][31:24]);
         wr(OFS_COUNT, 8'h28); // tag 5, beyond a maxtag of 01
         wr(OFS_MAXTAG, ab[i][23:16]);
         wr(OFS_DEVICE, ab[i][15:8]);
         run(ab[i][7:0], 2'h0);
         rc(OFS_ERROR, 8'h04);
         rc(OFS_STATUS, 8'h41);
      end
      wr(OFS_CONFIG, RST_CONFIG);
      wr(OFS_DEVICE, 8'h45);
      wr(OFS_COUNT, 8'h00);
      run(CMD_READ_MULTIPLE, 2'h0);
      chk("count", cap.count, 17'h00100);
      chk("lba", cap.lba, 48'h000005DDEEFF);
      chk("queued", cap.queued, 1'b0);
      rc(OFS_DEVICE, 8'h45);
      $display("aborts and multiple read done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(OFS_CONFIG, RST_CONFIG);
      rc(OFS_DEVICE, 8'h00);
      test_done();
   end
endmodule
